// file: bmf_map.svh
// register offsets, field positions, reset values and timing counts of the broadcast framer
`ifndef BMF_MAP_SVH
`define BMF_MAP_SVH

// register offsets on the plain register port
`define BMF_REG_CTRL 8'h00
`define BMF_REG_STATUS 8'h01
`define BMF_REG_MEM_ADDR 8'h02
`define BMF_REG_MEM_DATA 8'h03
`define BMF_REG_CFG 8'h04
`define BMF_REG_UDW1 8'h05
`define BMF_REG_UDW2 8'h06
`define BMF_REG_UDW3 8'h07

// control register fields
`define BMF_CTRL_START 0
`define BMF_CTRL_ENC_LO 1
`define BMF_CTRL_ENC_HI 2
`define BMF_CTRL_LINK 3

// configuration word fields, bit 15 is the leftmost bit of the word
`define BMF_CFG_FIRST_HI 11
`define BMF_CFG_FIRST_LO 6
`define BMF_CFG_COUNT_HI 5
`define BMF_CFG_COUNT_LO 0

// memory layout: user pages 0..47, then the two identifier pages
`define BMF_MEM_PAGES 50
`define BMF_SYS_PAGE 6'h2F
`define BMF_LAST_USER 6'h2F
`define BMF_ID_PAGE0 6'h30
`define BMF_ID_PAGE1 6'h31
`define BMF_CLASS_HI 63
`define BMF_CLASS_LO 56
`define BMF_CLASS_E0 8'hE0
`define BMF_CLASS_E2 8'hE2
`define BMF_CLASS_E3 8'hE3

// packet shape
`define BMF_PAGE_BITS 7'h40
`define BMF_FRAME_BITS 96
`define BMF_PRE_PPE 7'h0B
`define BMF_PRE_FM0 7'h12
`define BMF_PRE_MIL 7'h16
`define BMF_SYNC_PLAIN 6'h17
`define BMF_SYNC_LINK 6'h16
`define BMF_TRAILER_BITS 7'h08
`define BMF_CRC_SEED 5'h00
`define BMF_CRC_POLY 5'h09
`define BMF_CRC_DATA 67

// timing: clock cycles per data symbol and symbols in the inter-packet gap
`define BMF_SYM_CYCLES 4'h4
`define BMF_GAP_SYMS 8
`define BMF_GAP_CYCLES 6'h20
// cycles spent in load and launch, taken out of the gap count so the air gap stays exact
`define BMF_GAP_LEAD 6'h02

// reset values
`define BMF_RST_WORD 16'h0000
`define BMF_RST_PAGE 64'h0000_0000_0000_0000

`endif

// file: bmf_pkg.sv
// types shared by the broadcast framer modules
package bmf_pkg;

    // data encoding selected by software
    typedef enum logic [1:0] {
        BMF_ENC_PPE,
        BMF_ENC_FM0,
        BMF_ENC_M2,
        BMF_ENC_M4
    } bmf_enc_e;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bmf_bus_s;

    // serial transmit stream towards the modulator
    typedef struct packed {
        logic bit_val;
        logic en;
        logic sof;
    } bmf_tx_s;

endpackage : bmf_pkg

// file: bmf_crc5.sv
// chained crc-5 over page bits and packet number
`timescale 1ns/1ns
`include "bmf_map.svh"

module bmf_crc5 (
    // seed and message
    input wire logic [4:0] seed_i,
    input wire logic [`BMF_CRC_DATA-1:0] data_i,
    // result
    output logic [4:0] crc_o
);

    // walk the message msb first, one shift per bit
    always_comb begin
        logic [4:0] c;
        logic fb;
        c = seed_i;
        fb = 1'b0;
        for (int i = `BMF_CRC_DATA - 1; i >= 0; i--) begin
            fb = c[4] ^ data_i[i];
            c = {c[3:0], 1'b0} ^ (fb ? `BMF_CRC_POLY : 5'h00);
        end
        crc_o = c;
    end

endmodule : bmf_crc5

// file: bmf_ser.sv
// msb-first serialiser paced at one data symbol per symbol period
`timescale 1ns/1ns
`include "bmf_map.svh"

module bmf_ser (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // frame load
    input wire logic load_i,
    input wire logic [`BMF_FRAME_BITS-1:0] frame_i,
    input wire logic [6:0] len_i,
    // serial out
    output logic bit_o,
    output logic busy_o,
    output logic done_o
);

    logic [`BMF_FRAME_BITS-1:0] sh_r, sh_nxt; // left-aligned bits still to go
    logic [6:0] left_r, left_nxt; // symbols still to send
    logic [3:0] tick_r, tick_nxt; // cycles within the current symbol
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;

    // next-state: hold each bit for a full symbol, then shift
    always_comb begin
        sh_nxt = sh_r;
        left_nxt = left_r;
        tick_nxt = tick_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (load_i && !busy_r) begin
            sh_nxt = frame_i;
            left_nxt = len_i;
            tick_nxt = 4'h0;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (tick_r == `BMF_SYM_CYCLES - 4'h1) begin
                tick_nxt = 4'h0;
                sh_nxt = sh_r << 1;
                left_nxt = left_r - 7'h01;
                if (left_r == 7'h01) begin // last symbol over
                    busy_nxt = 1'b0;
                    done_nxt = 1'b1;
                end
            end else begin
                tick_nxt = tick_r + 4'h1;
            end
        end
    end

    // registers only
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sh_r <= '0;
            left_r <= 7'h00;
            tick_r <= 4'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            left_r <= left_nxt;
            tick_r <= tick_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign bit_o = sh_r[`BMF_FRAME_BITS-1];
    assign busy_o = busy_r;
    assign done_o = done_r;

endmodule : bmf_ser

// file: bmf_framer.sv
// broadcast message framer: page memory, register port and packet sequencer
//
// Behaviour
// - preamble plus one 64-bit page per packet
// - pulse-position: 11 preamble, 64 data, no end
// - fm0: 18 preamble, 64 data, end bit
// - miller: 22 preamble, 64 data, end bit
// - eight symbol gap between packets
// - linking adds 3-bit number and 5-bit crc
// - packet number counts remaining packets modulo 8
// - crc chained from previous packet's crc
// - first packet crc seed is zero
// - linking trailer only with miller 2 or 4
// - sync 010111 plain, 010110 with trailer
// - unstructured: identifier page then n user pages
// - structured: identifier pages, user memory verbatim
// - config word is first word of page 47
// - first page and count; zero sends none
// - page bit 63 is most significant
// - classes e0, e2, e3 are structured
`timescale 1ns/1ns
`include "bmf_map.svh"

module bmf_framer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire bmf_pkg::bmf_bus_s bus_i,
    output logic [15:0] rdata_o,
    // transmit stream
    output bmf_pkg::bmf_tx_s tx_o,
    output logic busy_o
);
    import bmf_pkg::*;

    // sequencer states
    typedef enum logic [1:0] {
        BMF_ST_IDLE,
        BMF_ST_LOAD,
        BMF_ST_SEND,
        BMF_ST_GAP
    } bmf_state_e;

    // page memory: user pages, system page 47 and the two identifier pages
    logic [63:0] mem_r [0:`BMF_MEM_PAGES-1];

    logic [15:0] ctrl_r, ctrl_nxt; // encoding and linking request; start reads zero
    logic [7:0] maddr_r, maddr_nxt; // page index in [7:2], word in [1:0]
    logic [15:0] rdata_r, rdata_nxt; // read data, valid the cycle after a read strobe
    logic mem_we; // one memory word written this cycle
    logic [5:0] mem_wpage;
    logic [1:0] mem_wword;

    bmf_state_e st_r, st_nxt;
    logic [5:0] idx_r, idx_nxt; // packet being sent, from zero
    logic [5:0] total_r, total_nxt; // packets in this message
    logic [4:0] crc_r, crc_nxt; // crc of the previous packet
    logic [5:0] gap_r, gap_nxt; // cycles left in the inter-packet gap
    bmf_enc_e enc_r, enc_nxt; // encoding frozen for the whole message
    logic link_r, link_nxt; // trailer frozen for the whole message
    logic [`BMF_FRAME_BITS-1:0] frame; // assembled packet, left-aligned
    logic [6:0] frame_len;
    logic [63:0] page; // page for the current packet
    logic [2:0] pkt_num;
    logic [4:0] crc_new;
    logic ser_bit, ser_busy, ser_done;
    bmf_tx_s tx_r, tx_nxt;
    logic sof_pend_r, sof_pend_nxt; // flags the first symbol of each packet

    // configuration word fields, always read live from the system page
    logic [15:0] cfg_word;
    logic [5:0] cfg_first, cfg_count;
    logic structured;
    assign cfg_word = mem_r[`BMF_SYS_PAGE][63:48];
    assign cfg_first = cfg_word[`BMF_CFG_FIRST_HI:`BMF_CFG_FIRST_LO];
    assign cfg_count = cfg_word[`BMF_CFG_COUNT_HI:`BMF_CFG_COUNT_LO];

    // class byte sits in the top eight bits of identifier page 0
    always_comb begin
        logic [7:0] cls;
        cls = mem_r[`BMF_ID_PAGE0][`BMF_CLASS_HI:`BMF_CLASS_LO];
        structured = (cls == `BMF_CLASS_E0) || (cls == `BMF_CLASS_E2)
                     || (cls == `BMF_CLASS_E3);
    end

    // register port: decode writes and prepare the registered read answer
    always_comb begin
        logic [5:0] rp;
        ctrl_nxt = ctrl_r;
        maddr_nxt = maddr_r;
        rdata_nxt = `BMF_RST_WORD;
        mem_we = 1'b0;
        mem_wpage = maddr_r[7:2];
        mem_wword = maddr_r[1:0];
        rp = maddr_r[7:2];
        ctrl_nxt[`BMF_CTRL_START] = 1'b0; // start is a one-cycle pulse
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                `BMF_REG_CTRL: begin
                    ctrl_nxt = bus_i.wdata;
                end
                `BMF_REG_MEM_ADDR: begin
                    maddr_nxt = bus_i.wdata[7:0];
                end
                `BMF_REG_MEM_DATA: begin
                    mem_we = 1'b1;
                    maddr_nxt = maddr_r + 8'h01; // auto-step through words and pages
                end
                `BMF_REG_CFG, `BMF_REG_UDW1, `BMF_REG_UDW2, `BMF_REG_UDW3: begin
                    mem_we = 1'b1; // these four live in the system page
                    mem_wpage = `BMF_SYS_PAGE;
                    mem_wword = bus_i.addr[1:0];
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                `BMF_REG_CTRL: begin
                    rdata_nxt = ctrl_r & ~16'h0001;
                end
                `BMF_REG_STATUS: begin
                    rdata_nxt = {2'b00, total_r, 2'b00, idx_r[5:0]} | {15'h0000, busy_o};
                end
                `BMF_REG_MEM_ADDR: begin
                    rdata_nxt = {8'h00, maddr_r};
                end
                `BMF_REG_MEM_DATA: begin
                    if (rp < `BMF_MEM_PAGES) begin
                        rdata_nxt = mem_r[rp][(6'd48 - {maddr_r[1:0], 4'h0}) +: 16];
                    end
                end
                `BMF_REG_CFG, `BMF_REG_UDW1, `BMF_REG_UDW2, `BMF_REG_UDW3: begin
                    rdata_nxt = mem_r[`BMF_SYS_PAGE][(6'd48 - {bus_i.addr[1:0], 4'h0}) +: 16];
                end
                default: begin
                    rdata_nxt = `BMF_RST_WORD; // unmapped reads return zero
                end
            endcase
        end
    end

    // page memory write; a word beyond the last page is ignored
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (int p = 0; p < `BMF_MEM_PAGES; p++) begin
                mem_r[p] <= `BMF_RST_PAGE;
            end
        end else if (mem_we && (mem_wpage < `BMF_MEM_PAGES)) begin
            mem_r[mem_wpage][(6'd48 - {mem_wword, 4'h0}) +: 16] <= bus_i.wdata;
        end
    end

    // choose the page for the current packet: identifier page(s) first, then user window
    always_comb begin
        logic [5:0] nid;
        logic [6:0] up;
        nid = structured ? 6'h02 : 6'h01;
        up = 7'h00;
        page = `BMF_RST_PAGE;
        if (idx_r < nid) begin
            page = mem_r[(idx_r == 6'h00) ? `BMF_ID_PAGE0 : `BMF_ID_PAGE1];
        end else begin
            // user pages go out exactly as stored; nothing is regenerated here
            up = {1'b0, cfg_first} + {1'b0, idx_r} - {1'b0, nid};
            if (up <= {1'b0, `BMF_LAST_USER}) begin
                page = mem_r[up[5:0]];
            end
        end
    end

    // remaining packets after this one, wrapped to three bits
    assign pkt_num = 3'(total_r - idx_r - 6'h01);

    // chained crc: seed is the previous packet's crc, zero for the first
    bmf_crc5 u_crc (
        .seed_i(crc_r),
        .data_i({page, pkt_num}),
        .crc_o(crc_new)
    );

    // assemble preamble, page, optional trailer and optional end bit, msb first
    always_comb begin
        logic [6:0] pre_len;
        logic [5:0] sync;
        logic [`BMF_FRAME_BITS-1:0] v;
        pre_len = `BMF_PRE_PPE;
        unique case (enc_r)
            BMF_ENC_PPE: pre_len = `BMF_PRE_PPE;
            BMF_ENC_FM0: pre_len = `BMF_PRE_FM0;
            BMF_ENC_M2, BMF_ENC_M4: pre_len = `BMF_PRE_MIL;
        endcase
        // leading preamble symbols are zero and the sync pattern closes it
        sync = link_r ? `BMF_SYNC_LINK : `BMF_SYNC_PLAIN;
        v = {{(`BMF_FRAME_BITS - 6){1'b0}}, sync};
        v = (v << `BMF_PAGE_BITS) | {32'h0000_0000, page};
        frame_len = pre_len + `BMF_PAGE_BITS;
        if (link_r) begin
            v = (v << `BMF_TRAILER_BITS) | {88'h0, pkt_num, crc_new};
            frame_len = frame_len + `BMF_TRAILER_BITS;
        end
        if (enc_r != BMF_ENC_PPE) begin
            v = (v << 1) | {95'h0, 1'b1};
            frame_len = frame_len + 7'h01;
        end
        frame = v << (7'(`BMF_FRAME_BITS) - frame_len);
    end

    // serialiser sends the frame one symbol at a time
    bmf_ser u_ser (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .load_i(st_r == BMF_ST_LOAD),
        .frame_i(frame),
        .len_i(frame_len),
        .bit_o(ser_bit),
        .busy_o(ser_busy),
        .done_o(ser_done)
    );

    // message sequencer
    always_comb begin
        logic [5:0] nuser;
        st_nxt = st_r;
        idx_nxt = idx_r;
        total_nxt = total_r;
        crc_nxt = crc_r;
        gap_nxt = gap_r;
        enc_nxt = enc_r;
        link_nxt = link_r;
        sof_pend_nxt = sof_pend_r;
        // either field zero means no user pages at all
        nuser = ((cfg_first == 6'h00) || (cfg_count == 6'h00)) ? 6'h00 : cfg_count;
        unique case (st_r)
            BMF_ST_IDLE: begin
                // a start while busy cannot happen here: only idle looks at it
                if (ctrl_r[`BMF_CTRL_START]) begin
                    enc_nxt = bmf_enc_e'(ctrl_r[`BMF_CTRL_ENC_HI:`BMF_CTRL_ENC_LO]);
                    link_nxt = ctrl_r[`BMF_CTRL_LINK]
                               && (ctrl_r[`BMF_CTRL_ENC_HI] == 1'b1);
                    total_nxt = (structured ? 6'h02 : 6'h01) + nuser;
                    idx_nxt = 6'h00;
                    crc_nxt = `BMF_CRC_SEED;
                    st_nxt = BMF_ST_LOAD;
                end
            end
            BMF_ST_LOAD: begin
                sof_pend_nxt = 1'b1;
                st_nxt = BMF_ST_SEND;
            end
            BMF_ST_SEND: begin
                if (ser_busy) begin
                    sof_pend_nxt = 1'b0;
                end
                if (ser_done) begin
                    crc_nxt = crc_new; // carried into the next packet
                    if (idx_r + 6'h01 == total_r) begin
                        st_nxt = BMF_ST_IDLE;
                    end else begin
                        idx_nxt = idx_r + 6'h01;
                        gap_nxt = `BMF_GAP_CYCLES - `BMF_GAP_LEAD; // launch delay counts too
                        st_nxt = BMF_ST_GAP;
                    end
                end
            end
            BMF_ST_GAP: begin
                // the gap is counted from the end of the last symbol
                if (gap_r == 6'h01) begin
                    st_nxt = BMF_ST_LOAD;
                end
                gap_nxt = gap_r - 6'h01;
            end
        endcase
    end

    // output stream, registered once more so every port comes from a flop
    always_comb begin
        tx_nxt.bit_val = ser_busy ? ser_bit : 1'b0;
        tx_nxt.en = ser_busy;
        tx_nxt.sof = ser_busy && sof_pend_r;
    end

    // sequencer, register port and output registers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_r <= BMF_ST_IDLE;
            idx_r <= 6'h00;
            total_r <= 6'h00;
            crc_r <= `BMF_CRC_SEED;
            gap_r <= 6'h00;
            enc_r <= BMF_ENC_PPE;
            link_r <= 1'b0;
            sof_pend_r <= 1'b0;
            ctrl_r <= `BMF_RST_WORD;
            maddr_r <= 8'h00;
            rdata_r <= `BMF_RST_WORD;
            tx_r <= '0;
            busy_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            total_r <= total_nxt;
            crc_r <= crc_nxt;
            gap_r <= gap_nxt;
            enc_r <= enc_nxt;
            link_r <= link_nxt;
            sof_pend_r <= sof_pend_nxt;
            ctrl_r <= ctrl_nxt;
            maddr_r <= maddr_nxt;
            rdata_r <= rdata_nxt;
            tx_r <= tx_nxt;
            busy_o <= (st_nxt != BMF_ST_IDLE);
        end
    end

    assign rdata_o = rdata_r;
    assign tx_o = tx_r;

endmodule : bmf_framer

// file: bmf_framer_assertions.sv
// port checker for the broadcast framer
`timescale 1ns/1ns
`include "bmf_map.svh"
module bmf_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire bmf_pkg::bmf_bus_s bus_i,
    input wire logic [15:0] rdata_o,
    // transmit side
    input wire bmf_pkg::bmf_tx_s tx_o,
    input wire logic busy_o
);
    import bmf_pkg::*;
    logic [9:0] on_r, on_nxt; // cycles of current packet
    logic [9:0] off_r, off_nxt; // idle cycles since last packet
    logic mid_r, mid_nxt; // a packet already ended in this message
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // next values of the timing counters
    always_comb begin
        on_nxt = tx_o.en ? on_r + 10'h001 : 10'h000;
        off_nxt = tx_o.en ? 10'h000 : off_r + 10'h001;
        mid_nxt = busy_o & (mid_r | ((on_r != 10'h000) & !tx_o.en));
    end
    // counters only register here
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            on_r <= 10'h000;
            off_r <= 10'h000;
            mid_r <= 1'b0;
        end else begin
            on_r <= on_nxt;
            off_r <= off_nxt;
            mid_r <= mid_nxt;
        end
    end
    chk_sof_inside: assert property (tx_o.sof |-> tx_o.en)
        else $error("start flag outside a packet");
    chk_tx_in_msg: assert property (tx_o.en |-> busy_o)
        else $error("packet outside a message");
    chk_sof_width: assert property ($rose(tx_o.sof) |-> $rose(tx_o.en) ##1 !tx_o.sof)
        else $error("start flag not a single clock at packet start");
    chk_symbol_hold: assert property ($rose(tx_o.en) |-> ##1 $stable(tx_o.bit_val) [*3])
        else $error("symbol not held four clocks");
    chk_lead_zero: assert property ($rose(tx_o.en) |-> !tx_o.bit_val)
        else $error("preamble does not open with zero");
    chk_pkt_len: assert property ($fell(tx_o.en) |-> on_r inside {10'h12C, 10'h14C, 10'h15C, 10'h17C})
        else $error("packet length not a legal bit count");
    chk_gap_len: assert property ($rose(tx_o.en) && mid_r |-> off_r == 10'h020)
        else $error("gap between packets not eight symbols");
    chk_start_tx: assert property (bus_i.wr && bus_i.addr == `BMF_REG_CTRL && bus_i.wdata[0]
        && !busy_o |-> ##[1:3] busy_o ##[0:6] tx_o.en)
        else $error("start did not launch a packet");
    chk_read_idle: assert property (!bus_i.rd |=> rdata_o == 16'h0000)
        else $error("read data outside read answer");
endmodule : bmf_chk
bind bmf_framer bmf_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .tx_o(tx_o), .busy_o(busy_o));

// file: bmf_reader.sv
// reader model: samples backscattered packets into a frame log
`timescale 1ns/1ns
module bmf_reader (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // backscatter stream
    input wire bmf_pkg::bmf_tx_s tx_i
);
    import bmf_pkg::*;
    logic [95:0] frames [0:63]; // received frames, right aligned
    logic [6:0] lens [0:63]; // bits per frame
    int n; // frames received
    logic [95:0] cur; // frame under reception
    logic [6:0] nb; // bits so far
    logic [1:0] ph; // phase inside a symbol
    // sample mid symbol so edges never decide the bit
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            n = 0;
            nb = 7'h00;
            ph = 2'h0;
            cur = '0;
        end else if (tx_i.en) begin
            if (ph == 2'h2) begin
                cur = {cur[94:0], tx_i.bit_val};
                nb = nb + 7'h01;
            end
            ph = ph + 2'h1;
        end else if (nb != 7'h00) begin
            frames[n % 64] = cur;
            lens[n % 64] = nb;
            n = n + 1;
            nb = 7'h00;
            ph = 2'h0;
            cur = '0;
        end
    end
endmodule : bmf_reader

// file: bmf_framer_bench.sv
// self-checking bench for the broadcast framer
`timescale 1ns/1ns
`include "bmf_map.svh"
module bmf_framer_bench;
    import bmf_pkg::*;
    logic clk_i;
    logic rst_b_i;
    bmf_bus_s bus_i;
    logic [15:0] rdata_o;
    bmf_tx_s tx_o;
    logic busy_o;
    int mismatches;
    int samples_checked;
    logic [4:0] chain_crc; // crc carried between packets
    // page contents; class byte decides the format
    localparam logic [63:0] ID0 = 64'h1234_5678_9ABC_DEF0;
    localparam logic [63:0] ID0S = 64'hE2A0_0000_0000_0001;
    localparam logic [63:0] ID1 = 64'h3000_1111_2222_3333;
    localparam logic [63:0] UP2 = 64'hA5A5_0F0F_C3C3_0001;
    localparam logic [63:0] UP3 = 64'h5A5A_F0F0_3C3C_8000;
    bmf_framer u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .tx_o(tx_o), .busy_o(busy_o));
    bmf_reader u_reader (.clk_i(clk_i), .rst_b_i(rst_b_i), .tx_i(tx_o));
    // 10 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task report_and_stop;
        $display("counts: %0d checked, %0d wrong", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word
    task chk_frame(input logic [95:0] got, input logic [95:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_frame
    // bounded wait on busy; a hang ends the run
    task wait_busy(input logic lvl, input int lim);
        int k;
        k = 0;
        while (busy_o !== lvl && k < lim) begin
            @(posedge clk_i);
            k++;
        end
        if (busy_o !== lvl) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, "busy wait ran out");
            report_and_stop;
        end
    endtask : wait_busy
    // one-cycle strobes, a free cycle after each
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1 d = rdata_o;
    endtask : rd
    // a page is four words, high word first
    task put_page(input logic [5:0] pg, input logic [63:0] v);
        wr(`BMF_REG_MEM_ADDR, {8'h00, pg, 2'b00});
        for (int i = 3; i >= 0; i--) wr(`BMF_REG_MEM_DATA, v[i*16 +: 16]);
    endtask : put_page
    function automatic logic [4:0] crc5(input logic [4:0] s, input logic [66:0] d);
        logic [4:0] c;
        c = s;
        for (int i = 66; i >= 0; i--) c = {c[3:0], 1'b0} ^ ((c[4] ^ d[i]) ? 5'h09 : 5'h00);
        return c;
    endfunction : crc5
    // expected packet, right aligned, with its bit count
    function automatic logic [95:0] build(input bmf_enc_e enc, input logic lk,
        input logic [63:0] pg, input logic [2:0] num, output logic [6:0] len);
        logic [95:0] f;
        f = {90'h0, (lk ? 6'h16 : 6'h17)};
        len = (enc == BMF_ENC_PPE) ? 7'h0B : (enc == BMF_ENC_FM0) ? 7'h12 : 7'h16;
        f = (f << 64) | {32'h0, pg};
        len = len + 7'h40;
        if (lk) begin
            chain_crc = crc5(chain_crc, {pg, num});
            f = (f << 8) | {88'h0, num, chain_crc};
            len = len + 7'h08;
        end
        if (enc != BMF_ENC_PPE) begin
            f = (f << 1) | 96'h1;
            len = len + 7'h01;
        end
        return f;
    endfunction : build
    // start a message and compare every packet the reader saw
    task run_msg(input bmf_enc_e enc, input logic lk, input int n,
        input logic [63:0] pg [0:3], input logic poke);
        int base;
        logic [95:0] e;
        logic [6:0] len;
        logic [15:0] d;
        base = u_reader.n;
        chain_crc = 5'h00;
        wr(`BMF_REG_CTRL, {12'h000, lk, enc, 1'b1});
        wait_busy(1'b1, 20);
        // first packet on air: total in [13:8], index zero, busy in bit 0
        rd(`BMF_REG_STATUS, d);
        chk_word(d, {2'b00, 6'(n), 8'h01}, "status");
        // a second start while busy must change nothing
        if (poke) wr(`BMF_REG_CTRL, {12'h000, 1'b0, BMF_ENC_FM0, 1'b1});
        wait_busy(1'b0, 3000);
        repeat (2) @(posedge clk_i);
        chk_word(16'(u_reader.n - base), 16'(n), "packet count");
        for (int i = 0; i < n; i++) begin
            e = build(enc, lk && enc[1], pg[i], 3'(n - 1 - i), len);
            chk_frame(u_reader.frames[(base + i) % 64], e, "frame");
            chk_word({9'h000, u_reader.lens[(base + i) % 64]}, {9'h000, len}, "length");
        end
    endtask : run_msg
    task t_regs;
        logic [15:0] d;
        rd(`BMF_REG_CFG, d);
        chk_word(d, 16'h0000, "config after reset");
        wr(`BMF_REG_UDW2, 16'hBEEF);
        rd(`BMF_REG_UDW2, d);
        chk_word(d, 16'hBEEF, "user word");
        rd(8'h3C, d);
        chk_word(d, 16'h0000, "unmapped read");
        put_page(6'h30, ID0);
        wr(`BMF_REG_MEM_ADDR, 16'h00C1);
        rd(`BMF_REG_MEM_DATA, d);
        chk_word(d, ID0[47:32], "page word");
        $display("test regs done");
    endtask : t_regs
    task t_ppe;
        logic [63:0] pg [0:3];
        put_page(6'h02, UP2);
        put_page(6'h03, UP3);
        wr(`BMF_REG_CFG, 16'h0082);
        pg = '{ID0, UP2, UP3, 64'h0};
        run_msg(BMF_ENC_PPE, 1'b1, 3, pg, 1'b1);
        $display("test pulse position done");
    endtask : t_ppe
    task t_fm0;
        logic [63:0] pg [0:3];
        pg = '{ID0, UP2, UP3, 64'h0};
        run_msg(BMF_ENC_FM0, 1'b0, 3, pg, 1'b0);
        $display("test fm0 done");
    endtask : t_fm0
    task t_link;
        logic [63:0] pg [0:3];
        put_page(6'h30, ID0S);
        put_page(6'h31, ID1);
        wr(`BMF_REG_CFG, 16'h00C1);
        pg = '{ID0S, ID1, UP3, 64'h0}; // item page passed on as stored
        run_msg(BMF_ENC_M4, 1'b1, 3, pg, 1'b0);
        $display("test linked miller done");
    endtask : t_link
    task t_cfg_page;
        logic [63:0] pg [0:3];
        logic [15:0] d;
        put_page(6'h2F, 64'h0003_0000_0000_0000);
        rd(`BMF_REG_CFG, d);
        chk_word(d, 16'h0003, "config from system page");
        pg = '{ID0S, ID1, 64'h0, 64'h0};
        run_msg(BMF_ENC_M2, 1'b0, 2, pg, 1'b0);
        $display("test system page done");
    endtask : t_cfg_page
    // main sequence
    initial begin
        bus_i = '0;
        rst_b_i = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        chain_crc = 5'h00;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_regs;
        t_ppe;
        t_fm0;
        t_link;
        t_cfg_page;
        report_and_stop;
    end
endmodule : bmf_framer_bench
